// ==== core/host_port_pkg.sv ====
// Constants shared by the host bus port and its DMA staging FIFO.
// Assumes a single 200 MHz system clock and synchronous active-low reset.
// Summary of operation
// - Register data crosses a two-way 32-bit bus, narrowed to 16 or 8 bits.
// - On a read strobe the device drives the selected register onto the bus.
// - Upper-word enable low adds the upper 16 data bits to the access.
// - Upper-byte enable low adds the upper byte of each active 16-bit word; the code ignores it while upper-word enable is low.
// - DMA request is raised only for buffer data, never for register access.
// - Interrupt output goes low whenever any recorded cause is active.
// - Active-low system reset returns all logic except the FIFO storage to its initial state.
// - With cycle source at 1 the cycle timer advances on the external tick.
// - The cycle output is a periodic clock derived from the cycle timer.
// - In automatic transmit mode the external start input begins sending.
// - Coupling select 0 means isolated coupling to the PHY, 1 means direct.
// - Access width comes from both lane enables; address bits 1 and 0 pick the lanes.
// - DMA requests follow the fill state of the buffer selected for DMA.
// - With cycle source at 0 the timer counts the 24.576 MHz PHY clock.
package host_port_pkg;

  localparam int unsigned ADDR_WIDTH = 7;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned LANES = 4;
  localparam int unsigned SYNC_STAGES = 2;

  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Address bits that select a byte lane within a register word.
  localparam logic [1:0] ADDR_LANE_MASK = 2'h3;

  // Cycle timer: 3072 ticks of the 24.576 MHz PHY clock make one 125 us
  // isochronous cycle, and 8000 cycles make one second.
  localparam logic [11:0] CYCLE_OFFSET_LAST = 12'hBFF;
  localparam logic [12:0] CYCLE_COUNT_LAST = 13'h1F3F;
  localparam int unsigned CYCLE_COUNT_WIDTH = 13;

  // The cycle output stays high for half of a nominal 125 us cycle.
  localparam int unsigned CYCLE_OUT_HIGH_NS = 62500;
  localparam int unsigned CYCLE_OUT_HIGH_CYCLES =
      (CYCLE_OUT_HIGH_NS * 1000) / CLK_PERIOD_PS;

  localparam int unsigned FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    WIDTH_8 = 2'b00,
    WIDTH_16 = 2'b01,
    WIDTH_32 = 2'b10
  } bus_width_t;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b000,
    ACC_READ_FETCH = 3'b001,
    ACC_READ_HOLD = 3'b010,
    ACC_WRITE = 3'b011,
    ACC_DMA_READ = 3'b100
  } access_state_t;

endpackage

// ==== core/dma_stage_fifo.sv ====
// Small synchronous FIFO that stages buffer words toward the host DMA path.
// Assumes both sides run on clk_sys; ready and valid follow the usual rule.
`timescale 1ns/1ps
module dma_stage_fifo
  import host_port_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg, wrPtr_next;
  logic [PTR_W-1:0] rdPtr_reg, rdPtr_next;
  logic [PTR_W:0] count_reg, count_next;
  logic push, pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign inReady = (count_reg != (PTR_W+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = store[rdPtr_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    wrPtr_next = push ? bump(wrPtr_reg) : wrPtr_reg;
    rdPtr_next = pop ? bump(rdPtr_reg) : rdPtr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  // The storage itself needs no reset; count gates every read of it.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wrPtr_reg] <= inData;
    end
  end

endmodule

// ==== core/link_host_bus_port.sv ====
// Host-side SRAM-style bus port of the link controller: register access,
// DMA of staged buffer words, interrupt, cycle timer and PHY coupling strap.
// Assumes host pins are asynchronous to clk_sys and held stable while strobed.
`timescale 1ns/1ps
module link_host_bus_port
  import host_port_pkg::*;
#(
  parameter int unsigned CYCLE_OUT_HIGH = CYCLE_OUT_HIGH_CYCLES,
  parameter int unsigned FIFO_WORDS = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [ADDR_WIDTH-1:0] hostRegSelectAddr,
  input wire logic [DATA_WIDTH-1:0] hostDataBusIn,
  output logic [DATA_WIDTH-1:0] hostDataBusOut,
  output logic hostDataBusOe,
  input wire logic writeStrobe_n,
  input wire logic readStrobe_n,
  input wire logic chipSelect_n,
  input wire logic upperWordEnable_n,
  input wire logic upperByteEnable_n,
  output logic dmaRequest,
  input wire logic dmaAcknowledge_n,
  output logic interrupt_n,
  input wire logic isoCycleTickIn,
  output logic isoCycleTickOut,
  input wire logic isoTxAutoStart,
  input wire logic couplingSelect,
  input wire logic phyMasterClockIn,
  output logic [ADDR_WIDTH-1:0] regAddr,
  output logic [LANES-1:0] regByteEnable,
  output logic [DATA_WIDTH-1:0] regWriteData,
  output logic regWriteStrobe,
  output logic regReadStrobe,
  input wire logic [DATA_WIDTH-1:0] regReadData,
  input wire logic [DATA_WIDTH-1:0] bufData,
  input wire logic bufValid,
  output logic bufReady,
  input wire logic dmaEnable,
  input wire logic interruptCauseActive,
  input wire logic cycleTimerEnable,
  input wire logic cycleTimerSourceSel,
  input wire logic isoAutoTxMode,
  output logic [CYCLE_COUNT_WIDTH-1:0] cycleCount,
  output logic isoTxStart,
  output logic directCoupling
);

  // Two-stage synchronisers for every host and PHY pin.
  localparam int unsigned NCTL = 9;
  logic [NCTL-1:0] ctlMeta_reg, ctlSync_reg;
  logic [ADDR_WIDTH-1:0] addrMeta_reg, addrSync_reg;
  logic [DATA_WIDTH-1:0] dataMeta_reg, dataSync_reg;
  logic csAct, rdAct, wrAct, uweAct, ubeAct, ackAct;
  logic cycInLvl, autoStartLvl, couplingLvl, phyClkLvl;
  logic cycInPrev_reg, autoStartPrev_reg, phyClkPrev_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctlMeta_reg <= '0;
      ctlSync_reg <= '0;
      addrMeta_reg <= '0;
      addrSync_reg <= '0;
      dataMeta_reg <= '0;
      dataSync_reg <= '0;
      cycInPrev_reg <= 1'b0;
      autoStartPrev_reg <= 1'b0;
      phyClkPrev_reg <= 1'b0;
    end else begin
      ctlMeta_reg <= {~chipSelect_n, ~readStrobe_n, ~writeStrobe_n,
                      ~upperWordEnable_n, ~upperByteEnable_n,
                      ~dmaAcknowledge_n, isoCycleTickIn, isoTxAutoStart,
                      phyMasterClockIn};
      ctlSync_reg <= ctlMeta_reg;
      addrMeta_reg <= hostRegSelectAddr;
      addrSync_reg <= addrMeta_reg;
      dataMeta_reg <= hostDataBusIn;
      dataSync_reg <= dataMeta_reg;
      cycInPrev_reg <= cycInLvl;
      autoStartPrev_reg <= autoStartLvl;
      phyClkPrev_reg <= phyClkLvl;
    end
  end

  assign {csAct, rdAct, wrAct, uweAct, ubeAct, ackAct,
          cycInLvl, autoStartLvl, phyClkLvl} = ctlSync_reg;

  // Coupling strap is a slow level, sampled through its own synchroniser.
  logic coupMeta_reg, coupSync_reg;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      coupMeta_reg <= 1'b0;
      coupSync_reg <= 1'b0;
    end else begin
      coupMeta_reg <= couplingSelect;
      coupSync_reg <= coupMeta_reg;
    end
  end
  assign couplingLvl = coupSync_reg;

  // Width decode and lane steering. The register word is big-endian on
  // the narrow buses: address 0 sits in bits 31..24.
  function automatic bus_width_t decodeWidth(input logic uwe,
                                             input logic ube);
    if (uwe) begin
      decodeWidth = WIDTH_32;
    end else if (ube) begin
      decodeWidth = WIDTH_16;
    end else begin
      decodeWidth = WIDTH_8;
    end
  endfunction

  function automatic logic [LANES-1:0] laneEnables(input bus_width_t w,
                                                   input logic [1:0] a);
    case (w)
      WIDTH_32: laneEnables = 4'hF;
      WIDTH_16: laneEnables = a[1] ? 4'h3 : 4'hC;
      WIDTH_8: laneEnables = 4'h8 >> a;
      default: laneEnables = 4'h0;
    endcase
  endfunction

  // Bits the narrow host word must be shifted up to reach its lanes.
  function automatic logic [4:0] laneShift(input bus_width_t w,
                                           input logic [1:0] a);
    case (w)
      WIDTH_16: laneShift = a[1] ? 5'h00 : 5'h10;
      WIDTH_8: laneShift = 5'(8 * (3 - int'(a)));
      default: laneShift = 5'h00;
    endcase
  endfunction

  // Access sequencer.
  access_state_t state_reg, state_next;
  logic [DATA_WIDTH-1:0] busOut_reg, busOut_next;
  logic busOe_reg, busOe_next;
  logic [ADDR_WIDTH-1:0] regAddr_reg, regAddr_next;
  logic [LANES-1:0] byteEn_reg, byteEn_next;
  logic [DATA_WIDTH-1:0] wrData_reg, wrData_next;
  logic wrStrobe_reg, wrStrobe_next;
  logic rdStrobe_reg, rdStrobe_next;
  logic [4:0] shift_reg, shift_next;
  logic dmaReq_reg, dmaReq_next;
  logic fifoPop;
  logic [DATA_WIDTH-1:0] fifoData;
  logic fifoValid;
  bus_width_t curWidth;
  logic [1:0] curLow;

  assign curWidth = decodeWidth(uweAct, ubeAct);
  assign curLow = addrSync_reg[1:0];

  always_comb begin
    state_next = state_reg;
    busOut_next = busOut_reg;
    busOe_next = busOe_reg;
    regAddr_next = regAddr_reg;
    byteEn_next = byteEn_reg;
    wrData_next = wrData_reg;
    shift_next = shift_reg;
    wrStrobe_next = 1'b0;
    rdStrobe_next = 1'b0;
    fifoPop = 1'b0;
    case (state_reg)
      ACC_IDLE: begin
        busOe_next = 1'b0;
        if (ackAct && rdAct && fifoValid) begin
          busOut_next = fifoData;
          busOe_next = 1'b1;
          state_next = ACC_DMA_READ;
        end else if (csAct && rdAct) begin
          regAddr_next = addrSync_reg & ~ADDR_WIDTH'(ADDR_LANE_MASK);
          byteEn_next = laneEnables(curWidth, curLow);
          shift_next = laneShift(curWidth, curLow);
          rdStrobe_next = 1'b1;
          state_next = ACC_READ_FETCH;
        end else if (csAct && wrAct) begin
          state_next = ACC_WRITE;
        end
      end
      ACC_READ_FETCH: begin
        busOut_next = regReadData >> shift_reg;
        busOe_next = csAct && rdAct;
        state_next = ACC_READ_HOLD;
      end
      ACC_READ_HOLD: begin
        if (!(csAct && rdAct)) begin
          busOe_next = 1'b0;
          state_next = ACC_IDLE;
        end
      end
      ACC_WRITE: begin
        if (wrAct && csAct) begin
          regAddr_next = addrSync_reg & ~ADDR_WIDTH'(ADDR_LANE_MASK);
          byteEn_next = laneEnables(curWidth, curLow);
          wrData_next = dataSync_reg << laneShift(curWidth, curLow);
        end else begin
          // Commit on the trailing edge, when data has been stable longest.
          wrStrobe_next = 1'b1;
          state_next = ACC_IDLE;
        end
      end
      ACC_DMA_READ: begin
        if (!rdAct || !ackAct) begin
          fifoPop = 1'b1;
          busOe_next = 1'b0;
          state_next = ACC_IDLE;
        end
      end
      default: begin
        busOe_next = 1'b0;
        state_next = ACC_IDLE;
      end
    endcase
    // Request is withheld during a beat so a word is never asked twice.
    dmaReq_next = dmaEnable && fifoValid && (state_next != ACC_DMA_READ)
                  && !fifoPop;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= ACC_IDLE;
      busOut_reg <= '0;
      busOe_reg <= 1'b0;
      regAddr_reg <= '0;
      byteEn_reg <= '0;
      wrData_reg <= '0;
      shift_reg <= '0;
      wrStrobe_reg <= 1'b0;
      rdStrobe_reg <= 1'b0;
      dmaReq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busOut_reg <= busOut_next;
      busOe_reg <= busOe_next;
      regAddr_reg <= regAddr_next;
      byteEn_reg <= byteEn_next;
      wrData_reg <= wrData_next;
      shift_reg <= shift_next;
      wrStrobe_reg <= wrStrobe_next;
      rdStrobe_reg <= rdStrobe_next;
      dmaReq_reg <= dmaReq_next;
    end
  end

  dma_stage_fifo #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .inData(bufData),
    .inValid(bufValid),
    .inReady(bufReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  // Cycle timer, cycle output, automatic start and interrupt.
  logic [11:0] cycOffset_reg, cycOffset_next;
  logic [CYCLE_COUNT_WIDTH-1:0] cycCount_reg, cycCount_next;
  logic [$clog2(CYCLE_OUT_HIGH+1)-1:0] outCnt_reg, outCnt_next;
  logic cycOut_reg, cycOut_next;
  logic txStart_reg, txStart_next;
  logic int_n_reg, int_n_next;
  logic direct_reg, direct_next;
  logic cycleCarry;

  always_comb begin
    cycOffset_next = cycOffset_reg;
    cycleCarry = 1'b0;
    if (cycleTimerEnable) begin
      if (cycleTimerSourceSel) begin
        // External tick defines the cycle; the fine offset is not kept.
        cycOffset_next = '0;
        cycleCarry = cycInLvl && !cycInPrev_reg;
      end else if (phyClkLvl && !phyClkPrev_reg) begin
        if (cycOffset_reg == CYCLE_OFFSET_LAST) begin
          cycOffset_next = '0;
          cycleCarry = 1'b1;
        end else begin
          cycOffset_next = cycOffset_reg + 1'b1;
        end
      end
    end
    cycCount_next = cycCount_reg;
    if (cycleCarry) begin
      cycCount_next = (cycCount_reg == CYCLE_COUNT_LAST) ? '0
                      : cycCount_reg + 1'b1;
    end
    // Output clock: high for a fixed half period after each carry.
    outCnt_next = outCnt_reg;
    cycOut_next = cycOut_reg;
    if (cycleCarry) begin
      outCnt_next = '0;
      cycOut_next = 1'b1;
    end else if (cycOut_reg) begin
      if (outCnt_reg == $bits(outCnt_reg)'(CYCLE_OUT_HIGH - 1)) begin
        cycOut_next = 1'b0;
      end else begin
        outCnt_next = outCnt_reg + 1'b1;
      end
    end
    txStart_next = isoAutoTxMode && autoStartLvl
                   && !autoStartPrev_reg;
    int_n_next = !interruptCauseActive;
    direct_next = couplingLvl;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cycOffset_reg <= '0;
      cycCount_reg <= '0;
      outCnt_reg <= '0;
      cycOut_reg <= 1'b0;
      txStart_reg <= 1'b0;
      int_n_reg <= 1'b1;
      direct_reg <= 1'b0;
    end else begin
      cycOffset_reg <= cycOffset_next;
      cycCount_reg <= cycCount_next;
      outCnt_reg <= outCnt_next;
      cycOut_reg <= cycOut_next;
      txStart_reg <= txStart_next;
      int_n_reg <= int_n_next;
      direct_reg <= direct_next;
    end
  end

  assign hostDataBusOut = busOut_reg;
  assign hostDataBusOe = busOe_reg;
  assign dmaRequest = dmaReq_reg;
  assign interrupt_n = int_n_reg;
  assign isoCycleTickOut = cycOut_reg;
  assign regAddr = regAddr_reg;
  assign regByteEnable = byteEn_reg;
  assign regWriteData = wrData_reg;
  assign regWriteStrobe = wrStrobe_reg;
  assign regReadStrobe = rdStrobe_reg;
  assign cycleCount = cycCount_reg;
  assign isoTxStart = txStart_reg;
  assign directCoupling = direct_reg;

endmodule

// ==== verification/link_host_bus_port_props.sv ====
// Port-level assertions for the host bus port, bound to each instance.
// Assumes one clock domain and reset held low for several edges.
`timescale 1ns/1ps
module link_host_bus_port_props
  import host_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic writeStrobe_n,
  input wire logic readStrobe_n,
  input wire logic chipSelect_n,
  input wire logic dmaAcknowledge_n,
  input wire logic hostDataBusOe,
  input wire logic regWriteStrobe,
  input wire logic regReadStrobe,
  input wire logic interrupt_n,
  input wire logic interruptCauseActive,
  input wire logic dmaRequest,
  input wire logic dmaEnable,
  input wire logic isoTxAutoStart,
  input wire logic isoAutoTxMode,
  input wire logic isoTxStart,
  input wire logic couplingSelect,
  input wire logic directCoupling,
  input wire logic [CYCLE_COUNT_WIDTH-1:0] cycleCount
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence sRdStart;
    $fell(readStrobe_n) && !chipSelect_n && dmaAcknowledge_n;
  endsequence
  sequence sIsoStart;
    isoAutoTxMode && $rose(isoTxAutoStart);
  endsequence
  AST_NO_CS: assert property (
    chipSelect_n [*6] |-> !regWriteStrobe && !regReadStrobe)
    else $error("register strobe without chip select");
  AST_WR_COMMIT: assert property (
    regWriteStrobe |-> $past(writeStrobe_n, 2) || $past(chipSelect_n, 2))
    else $error("write committed while strobe still held");
  AST_RD_TAKE: assert property (
    sRdStart |-> ##[2:6] regReadStrobe)
    else $error("read strobe not taken");
  AST_RD_OE: assert property (
    regReadStrobe |=> hostDataBusOe)
    else $error("read data not driven");
  AST_OE_REL: assert property (
    readStrobe_n [*6] |-> !hostDataBusOe)
    else $error("bus driven without read");
  AST_INT: assert property (
    $past(reset_n) |-> interrupt_n == !$past(interruptCauseActive))
    else $error("interrupt output wrong");
  AST_DMA_GATE: assert property (
    !dmaEnable [*2] |-> !dmaRequest)
    else $error("request while DMA disabled");
  AST_ISO_START: assert property (
    sIsoStart |-> ##[3:4] isoTxStart)
    else $error("transmit start missing");
  AST_ISO_OFF: assert property (
    !isoAutoTxMode [*6] |-> !isoTxStart)
    else $error("transmit start outside auto mode");
  AST_COUPLING: assert property (
    $stable(couplingSelect) [*4] |-> directCoupling == couplingSelect)
    else $error("coupling select not followed");
  AST_COUNT_STEP: assert property (
    $past(reset_n) && $changed(cycleCount) |-> cycleCount ==
    ($past(cycleCount) == CYCLE_COUNT_LAST ? 13'h0
     : $past(cycleCount) + 13'h1))
    else $error("cycle count skipped");
endmodule

bind link_host_bus_port link_host_bus_port_props link_host_bus_port_props_inst (
  .clk_sys, .reset_n, .writeStrobe_n, .readStrobe_n, .chipSelect_n,
  .dmaAcknowledge_n, .hostDataBusOe, .regWriteStrobe, .regReadStrobe,
  .interrupt_n, .interruptCauseActive, .dmaRequest, .dmaEnable,
  .isoTxAutoStart, .isoAutoTxMode, .isoTxStart, .couplingSelect,
  .directCoupling, .cycleCount
);

// ==== verification/host_bus_model.sv ====
// Behavioural host processor on the SRAM-style bus of the link controller.
// Assumes the bench resolves the shared data lines and feeds them back.
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_sys,
  input wire logic [31:0] busIn,
  output logic [6:0] hostRegSelectAddr,
  output logic [31:0] hostData,
  output logic hostEn,
  output logic writeStrobe_n,
  output logic readStrobe_n,
  output logic chipSelect_n,
  output logic upperWordEnable_n,
  output logic upperByteEnable_n,
  output logic dmaAcknowledge_n
);
  initial begin
    hostRegSelectAddr = 7'h00;
    hostData = 32'h0000_0000;
    hostEn = 1'b0;
    {writeStrobe_n, readStrobe_n, chipSelect_n} = 3'h7;
    {upperWordEnable_n, upperByteEnable_n, dmaAcknowledge_n} = 3'h7;
  end
  // Strobes are held well past the pin synchronisers, so no access is lost.
  task automatic acc(input logic wr, input logic dma, input logic sel,
      input logic [1:0] w, input logic [6:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk_sys);
    hostRegSelectAddr <= a;
    upperWordEnable_n <= w != 2'h2;
    upperByteEnable_n <= w == 2'h0;
    hostData <= d;
    hostEn <= wr;
    chipSelect_n <= !(sel && !dma);
    dmaAcknowledge_n <= !dma;
    repeat (4) @(posedge clk_sys);
    writeStrobe_n <= !wr;
    readStrobe_n <= wr;
    repeat (8) @(posedge clk_sys);
    q = busIn;
    writeStrobe_n <= 1'b1;
    readStrobe_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chipSelect_n <= 1'b1;
    dmaAcknowledge_n <= 1'b1;
    hostEn <= 1'b0;
  endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the host bus port with a host model on its pins.
// Assumes the port's FIFO, cycle timer and strap logic sit inside the top.
`timescale 1ns/1ps
module tb;
  import host_port_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] flt = 32'h0000_0000, bufData = 32'h0000_0000;
  logic bufValid = 1'b0, dmaEnable = 1'b0, interruptCauseActive = 1'b0;
  logic cycleTimerEnable = 1'b1, cycleTimerSourceSel = 1'b1;
  logic isoAutoTxMode = 1'b0, isoTxAutoStart = 1'b0, couplingSelect = 1'b0;
  logic isoCycleTickIn = 1'b0;
  logic [2:0] phyDiv = 3'h0;
  logic [31:0] hostDataBusIn, hostDataBusOut, hostData, regReadData;
  logic [31:0] regWriteData;
  logic [6:0] hostRegSelectAddr, regAddr;
  logic [3:0] regByteEnable;
  logic [12:0] cycleCount;
  logic hostDataBusOe, hostEn, writeStrobe_n, readStrobe_n, chipSelect_n;
  logic upperWordEnable_n, upperByteEnable_n, dmaAcknowledge_n, dmaRequest;
  logic interrupt_n, isoCycleTickOut, regWriteStrobe, regReadStrobe;
  logic bufReady, isoTxStart, directCoupling, phyMasterClockIn;
  int nErrors = 0, checkCount = 0, nW = 0, nR = 0, nOe = 0, nTx = 0, nTo = 0;

  function automatic logic [31:0] rdv(input logic [6:0] a);
    return {a, 1'b1, a, 1'b0, a, 1'b1, a, 1'b0};
  endfunction

  // Released lines show a changing pattern so a stale value cannot pass.
  assign hostDataBusIn = hostDataBusOe ? hostDataBusOut
                         : hostEn ? hostData : flt;
  assign regReadData = rdv(regAddr);
  assign phyMasterClockIn = phyDiv[2];
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    flt <= ~flt ^ 32'h0000_005A;
    phyDiv <= phyDiv + 3'h1;
    if (regWriteStrobe === 1'b1) nW <= nW + 1;
    if (regReadStrobe === 1'b1) nR <= nR + 1;
    if (hostDataBusOe === 1'b1) nOe <= nOe + 1;
    if (isoTxStart === 1'b1) nTx <= nTx + 1;
    if ($rose(isoCycleTickOut)) nTo <= nTo + 1;
  end

  link_host_bus_port #(.CYCLE_OUT_HIGH(8), .FIFO_WORDS(4))
      link_host_bus_port_inst (
    .clk_sys, .reset_n, .hostRegSelectAddr, .hostDataBusIn, .hostDataBusOut,
    .hostDataBusOe, .writeStrobe_n, .readStrobe_n, .chipSelect_n,
    .upperWordEnable_n, .upperByteEnable_n, .dmaRequest, .dmaAcknowledge_n,
    .interrupt_n, .isoCycleTickIn, .isoCycleTickOut, .isoTxAutoStart,
    .couplingSelect, .phyMasterClockIn, .regAddr, .regByteEnable,
    .regWriteData, .regWriteStrobe, .regReadStrobe, .regReadData, .bufData,
    .bufValid, .bufReady, .dmaEnable, .interruptCauseActive, .cycleTimerEnable,
    .cycleTimerSourceSel, .isoAutoTxMode, .cycleCount, .isoTxStart,
    .directCoupling);
  host_bus_model host (.clk_sys, .busIn(hostDataBusIn), .hostRegSelectAddr,
    .hostData, .hostEn, .writeStrobe_n, .readStrobe_n, .chipSelect_n,
    .upperWordEnable_n, .upperByteEnable_n, .dmaAcknowledge_n);

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tRegs();
    logic [31:0] q, d, m;
    int sh, w0;
    logic [6:0] a;
    for (int w = 0; w < 3; w++) begin
      for (int i = 0; i < 4; i++) begin
        a = 7'h24 + 7'(i);
        d = 32'h8C4E_17B3 + 32'(w * 4 + i);
        sh = (w == 2) ? 0 : (w == 1) ? (a[1] ? 0 : 16) : 24 - 8 * a[1:0];
        m = (w == 2) ? 32'hFFFF_FFFF : ((w == 1) ? 32'hFFFF : 32'hFF) << sh;
        w0 = nW;
        host.acc(1'b1, 1'b0, 1'b1, 2'(w), a, d, q);
        cmp(nW - w0, 1);
        cmp({regAddr, regByteEnable},
          {a & 7'h7C, m[24], m[16], m[8], m[0]});
        cmp(regWriteData & m, (d << sh) & m);
        host.acc(1'b0, 1'b0, 1'b1, 2'(w), a, 32'h0, q);
        cmp(q & (m >> sh),
          (rdv(a & 7'h7C) >> sh) & (m >> sh));
      end
    end
  endtask

  task automatic tNoCs();
    logic [31:0] q;
    int s0;
    s0 = nW + nR + nOe;
    host.acc(1'b1, 1'b0, 1'b0, 2'h2, 7'h10, 32'hFFFF_0000, q);
    host.acc(1'b0, 1'b0, 1'b0, 2'h2, 7'h10, 32'h0, q);
    cmp(nW + nR + nOe - s0, 0);
  endtask

  task automatic tDma();
    logic [31:0] q;
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      bufValid <= 1'b1;
      bufData <= 32'hD000_0000 + 32'(n);
      @(negedge clk_sys);
      if (bufReady !== 1'b1) break;
      n++;
    end
    @(posedge clk_sys);
    bufValid <= 1'b0;
    cmp(n, FIFO_DEPTH);
    repeat (4) @(posedge clk_sys);
    cmp(dmaRequest, 0);
    dmaEnable <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp(dmaRequest, 1);
    for (int j = 0; j < n; j++) begin
      host.acc(1'b0, 1'b1, 1'b0, 2'h2, 7'h00, 32'h0, q);
      cmp(q, 32'hD000_0000 + 32'(j));
    end
    repeat (6) @(posedge clk_sys);
    cmp(dmaRequest, 0);
    dmaEnable <= 1'b0;
  endtask

  task automatic tStraps();
    int x0;
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk_sys) couplingSelect <= 1'(v);
      interruptCauseActive <= 1'(v);
      isoAutoTxMode <= 1'(v);
      x0 = nTx;
      repeat (6) @(posedge clk_sys);
      cmp(directCoupling, v);
      cmp(interrupt_n, !v);
      isoTxAutoStart <= 1'b1;
      repeat (10) @(posedge clk_sys);
      isoTxAutoStart <= 1'b0;
      cmp(nTx - x0, v);
    end
  endtask

  task automatic tCycle();
    logic [12:0] c0;
    int t0;
    c0 = cycleCount;
    t0 = nTo;
    repeat (3) begin
      @(posedge clk_sys) isoCycleTickIn <= 1'b1;
      repeat (6) @(posedge clk_sys);
      isoCycleTickIn <= 1'b0;
      repeat (6) @(posedge clk_sys);
    end
    cmp(cycleCount, c0 + 13'h3);
    cmp(nTo - t0, 3);
    repeat (25000) @(posedge clk_sys);
    cmp(cycleCount, c0 + 13'h3);
    cycleTimerSourceSel <= 1'b0;
    repeat (24400) @(posedge clk_sys);
    cmp(cycleCount, c0 + 13'h3);
    repeat (300) @(posedge clk_sys);
    cmp(cycleCount, c0 + 13'h4);
  endtask

  task automatic finishTest();
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cmp({hostDataBusOe, dmaRequest, interrupt_n, isoTxStart, directCoupling,
      cycleCount}, {5'h04, 13'h0});
    tStraps();
    tRegs();
    tNoCs();
    tDma();
    tCycle();
    finishTest();
  end

  initial begin
    #500000;
    nErrors++;
    finishTest();
  end
endmodule
